//--- logic/fcfe_front_end.sv
// Command front end of a serial NOR flash: framing, opcode decode,
// byte-boundary checks and the volatile upper address byte.
// Assumes serial clock well below mclk / 8; array, protection and
// status contents live outside and talk over the same-clock ports.
//
// What this block does
// - Three-byte mode: upper address byte sits above the 24 received bits.
// - Bit zero of that byte is address bit 24, choosing array half.
// - Address carry never changes the byte; only its write command does.
// - Four-byte mode: four address bytes taken, upper byte ignored.
// - Four-byte mode: upper byte read and write commands not accepted.
// - Byte bits 7 to 1 map to address bits 31 to 25.
// - Upper address byte is volatile, kept apart from status bytes.
// - After select low, opcode arrives MSB first, sampled on rising clock.
// - Opcode byte first, then address, data, both or nothing.
// - Reads, status reads, release and ID shift out; deselect anytime.
// - Modifying commands need deselect at a multiple of eight clocks.
// - Partial page program byte: no programming, write enable stays set.
// - Decode 06h write enable, 50h volatile enable, 04h write disable.
// - Opcodes 05h, 35h, 15h return status byte one, two, three.
// - 01h takes one or two status bytes; 31h and 11h take one.
// - ABh plus three dummies returns ID; bare ABh only releases.
// - 6Ch: serial opcode, four address, one dummy, quad data out.
// - BCh: address and dummy on two lanes, data out on two lanes.
`timescale 1ns/1ps
`default_nettype none

module fcfe_front_end
  import fcfe_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic [IO_W-1:0] spi_io_in,
  output logic [IO_W-1:0] spi_io_out,
  output logic [IO_W-1:0] spi_io_oe,
  // Device state from the core
  input wire logic four_byte_mode,
  input wire logic [7:0] status_byte_one,
  input wire logic [7:0] status_byte_two,
  input wire logic [7:0] status_byte_three,
  input wire logic [7:0] read_byte,
  // Commands to the core
  output logic op_commit,
  output fcfe_cmd_t op_info,
  output logic read_start,
  output logic read_byte_next,
  output logic prog_byte_valid,
  output logic [7:0] prog_byte,
  output logic powerdown_release,
  output logic sr_write_valid,
  output fcfe_srw_t sr_write,
  output logic [7:0] upper_address_byte
);

  logic [5:0] pins_s;
  logic sck_s, cs_act, sck_prev_reg, cs_prev_reg;
  logic sck_rise, sck_fall, cs_start, cs_end;
  logic [BYTE_W-1:0] byte_val;
  logic byte_done, sample;
  logic [2:0] lanes_in;
  fcfe_state_t state_reg, adv_state;
  fcfe_cls_t cls_reg, dec;
  logic [2:0] phase_cnt_reg;
  logic [2:0] clk_mod8_reg;
  logic [ADDR_W-1:0] addr_sr_reg;
  logic [ADDR_W-1:0] addr_now;
  logic [1:0] din_cnt_reg;
  logic [7:0] din_one_reg, din_two_reg, opcode_reg;
  logic [BYTE_W-1:0] out_sr_reg, out_src, out_data;
  logic [2:0] out_cnt_reg;
  logic bound_ok, enter_data;

  // ==========================================================
  // Pin synchronisers and edge detection
  fcfe_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({spi_cs_n, spi_clk, spi_io_in}),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[4];
  assign cs_act = ~pins_s[5];

  // Previous levels for edges
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_act;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_reg & cs_act;
  assign sck_fall = ~sck_s & sck_prev_reg & cs_act;
  assign cs_start = cs_act & ~cs_prev_reg;
  assign cs_end = ~cs_act & cs_prev_reg;

  // ==========================================================
  // Input byte assembly
  assign lanes_in = (state_reg == S_ADDR || state_reg == S_DUMMY) ? cls_reg.in_lanes : LANES_1;
  assign sample = sck_rise & (state_reg != S_DOUT) & (state_reg != S_IDLE)
                & (state_reg != S_SKIP);

  fcfe_shift u_shift (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(cs_start),
    .sample(sample),
    .lanes(lanes_in),
    .io_in(pins_s[3:0]),
    .byte_val(byte_val),
    .byte_done(byte_done)
  );

  // ==========================================================
  // Opcode decode
  function automatic fcfe_cls_t classify(input logic [7:0] opc, input logic fourb);
    fcfe_cls_t c;
    logic [2:0] abytes;
    abytes = fourb ? ADDR_BYTES_4 : ADDR_BYTES_3;
    c = '{K_IGNORE, ADDR_NONE, DUMMY_NONE, LANES_1, LANES_1};
    case (opc)
      OPC_WRITE_ENABLE, OPC_VOL_SR_WRITE_ENABLE, OPC_WRITE_DISABLE,
      OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B, OPC_DEEP_POWER_DOWN: c.kind = K_SINGLE;
      OPC_READ_SR_ONE, OPC_READ_SR_TWO, OPC_READ_SR_THREE: c.kind = K_SR_READ;
      OPC_WRITE_SR, OPC_WRITE_SR_TWO, OPC_WRITE_SR_THREE: c.kind = K_SRW;
      OPC_RELEASE_PD: begin
        c.kind = K_RPD;
        c.dummy_bytes = DUMMY_ID;
      end
      OPC_PAGE_PROGRAM, OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K: begin
        c.kind = (opc == OPC_PAGE_PROGRAM) ? K_PROG : K_ERASE;
        c.addr_bytes = abytes;
      end
      OPC_PAGE_PROGRAM_4B, OPC_ERASE_4K_4B, OPC_ERASE_32K_4B, OPC_ERASE_64K_4B: begin
        c.kind = (opc == OPC_PAGE_PROGRAM_4B) ? K_PROG : K_ERASE;
        c.addr_bytes = ADDR_BYTES_4;
      end
      OPC_READ, OPC_FAST_READ: begin
        c.kind = K_ARRAY_READ;
        c.addr_bytes = abytes;
        c.dummy_bytes = (opc == OPC_FAST_READ) ? DUMMY_ONE : DUMMY_NONE;
      end
      OPC_READ_4B, OPC_FAST_READ_4B: begin
        c.kind = K_ARRAY_READ;
        c.addr_bytes = ADDR_BYTES_4;
        c.dummy_bytes = (opc == OPC_FAST_READ_4B) ? DUMMY_ONE : DUMMY_NONE;
      end
      OPC_QUAD_OUT_READ_4B: begin
        c = '{K_ARRAY_READ, ADDR_BYTES_4, DUMMY_ONE, LANES_1, LANES_4};
      end
      OPC_DUAL_IO_READ_4B: begin
        c = '{K_ARRAY_READ, ADDR_BYTES_4, DUMMY_ONE, LANES_2, LANES_2};
      end
      OPC_UPPER_ADDR_WRITE: c.kind = fourb ? K_IGNORE : K_UA_WRITE;
      OPC_UPPER_ADDR_READ: c.kind = fourb ? K_IGNORE : K_UA_READ;
      default: c.kind = K_IGNORE;
    endcase
    return c;
  endfunction : classify

  // State entered once the input phases are done
  function automatic fcfe_state_t data_state(input fcfe_cls_t c);
    if (c.kind == K_SR_READ || c.kind == K_ARRAY_READ || c.kind == K_RPD
        || c.kind == K_UA_READ) begin
      return S_DOUT;
    end
    return S_DIN;
  endfunction : data_state

  assign dec = classify(byte_val, four_byte_mode);
  assign addr_now = {addr_sr_reg[23:0], byte_val};

  // Start address: upper byte above low 24 bits unless four bytes given
  function automatic logic [ADDR_W-1:0] form_addr(input logic [ADDR_W-1:0] raw,
                                                  input logic full, input logic [7:0] ua);
    return full ? raw : {ua, raw[LOW_ADDR_W-1:0]};
  endfunction : form_addr

  // Phase sequencing after each completed byte
  always_comb begin
    adv_state = state_reg;
    case (state_reg)
      S_OPCODE: begin
        if (dec.kind == K_IGNORE) begin
          adv_state = S_SKIP;
        end else if (dec.addr_bytes != ADDR_NONE) begin
          adv_state = S_ADDR;
        end else if (dec.dummy_bytes != DUMMY_NONE) begin
          adv_state = S_DUMMY;
        end else begin
          adv_state = data_state(dec);
        end
      end
      S_ADDR: begin
        if (phase_cnt_reg + 3'h1 == cls_reg.addr_bytes) begin
          adv_state = (cls_reg.dummy_bytes != DUMMY_NONE) ? S_DUMMY : data_state(cls_reg);
        end
      end
      S_DUMMY: begin
        if (phase_cnt_reg[1:0] + 2'h1 == cls_reg.dummy_bytes) begin
          adv_state = data_state(cls_reg);
        end
      end
      default: adv_state = state_reg;
    endcase
  end

  assign enter_data = byte_done & (adv_state == S_DOUT) & (state_reg != S_DOUT);

  // ==========================================================
  // Transaction state machine
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      cls_reg <= '{K_IGNORE, ADDR_NONE, DUMMY_NONE, LANES_1, LANES_1};
      opcode_reg <= 8'h00;
      phase_cnt_reg <= 3'h0;
    end else if (cs_start) begin
      state_reg <= S_OPCODE;
      phase_cnt_reg <= 3'h0;
    end else if (!cs_act) begin
      state_reg <= S_IDLE;
    end else if (byte_done) begin
      state_reg <= adv_state;
      phase_cnt_reg <= (adv_state != state_reg) ? 3'h0 : phase_cnt_reg + 3'h1;
      if (state_reg == S_OPCODE) begin
        cls_reg <= dec;
        opcode_reg <= byte_val;
      end
    end
  end

  // ==========================================================
  // Clock count modulo eight and address/data capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_mod8_reg <= CLK_MOD8_ZERO;
    end else if (cs_start) begin
      clk_mod8_reg <= CLK_MOD8_ZERO;
    end else if (sck_rise) begin
      clk_mod8_reg <= clk_mod8_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_sr_reg <= 32'h0000_0000;
      din_cnt_reg <= DIN_NONE;
      din_one_reg <= 8'h00;
      din_two_reg <= 8'h00;
    end else if (cs_start) begin
      din_cnt_reg <= DIN_NONE;
    end else if (byte_done && state_reg == S_ADDR) begin
      addr_sr_reg <= addr_now;
    end else if (byte_done && state_reg == S_DIN) begin
      if (din_cnt_reg == DIN_NONE) begin
        din_one_reg <= byte_val;
      end else if (din_cnt_reg == DIN_ONE) begin
        din_two_reg <= byte_val;
      end
      if (din_cnt_reg != DIN_MAX) begin
        din_cnt_reg <= din_cnt_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // Deselect checks and commits
  assign bound_ok = cs_end & (clk_mod8_reg == CLK_MOD8_ZERO) & (state_reg == S_DIN);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_commit <= 1'b0;
      read_start <= 1'b0;
      op_info <= '0;
      prog_byte_valid <= 1'b0;
      prog_byte <= 8'h00;
      powerdown_release <= 1'b0;
    end else begin
      op_commit <= 1'b0;
      read_start <= 1'b0;
      prog_byte_valid <= 1'b0;
      powerdown_release <= 1'b0;
      if (byte_done && state_reg == S_OPCODE && dec.kind == K_RPD) begin
        powerdown_release <= 1'b1;
        op_info <= '{byte_val, 32'h0000_0000};
      end
      if (enter_data && state_reg != S_OPCODE && cls_reg.kind == K_ARRAY_READ) begin
        read_start <= 1'b1;
        op_info <= '{opcode_reg, form_addr((state_reg == S_ADDR) ? addr_now : addr_sr_reg,
                     cls_reg.addr_bytes == ADDR_BYTES_4, upper_address_byte)};
      end
      if (byte_done && state_reg == S_DIN && cls_reg.kind == K_PROG) begin
        prog_byte_valid <= 1'b1;
        prog_byte <= byte_val;
      end
      // Partial last byte leaves program undone and write enable intact
      if (bound_ok && (cls_reg.kind == K_SINGLE || cls_reg.kind == K_ERASE
          || (cls_reg.kind == K_PROG && din_cnt_reg != DIN_NONE))) begin
        op_commit <= 1'b1;
        op_info <= '{opcode_reg, form_addr(addr_sr_reg, cls_reg.addr_bytes == ADDR_BYTES_4,
                     upper_address_byte)};
      end
    end
  end

  // Status byte writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_write_valid <= 1'b0;
      sr_write <= '0;
    end else begin
      sr_write_valid <= 1'b0;
      if (bound_ok && cls_reg.kind == K_SRW && din_cnt_reg != DIN_NONE) begin
        sr_write_valid <= 1'b1;
        if (opcode_reg == OPC_WRITE_SR) begin
          sr_write <= '{(din_cnt_reg == DIN_ONE) ? SRW_SEL_ONE : (SRW_SEL_ONE | SRW_SEL_TWO),
                        din_one_reg, din_two_reg, 8'h00};
        end else if (opcode_reg == OPC_WRITE_SR_TWO) begin
          sr_write <= '{SRW_SEL_TWO, 8'h00, din_one_reg, 8'h00};
        end else begin
          sr_write <= '{SRW_SEL_THREE, 8'h00, 8'h00, din_one_reg};
        end
      end
    end
  end

  // Volatile upper address byte, apart from status bytes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_address_byte <= UPPER_ADDR_RESET;
    end else if (bound_ok && cls_reg.kind == K_UA_WRITE && din_cnt_reg != DIN_NONE) begin
      upper_address_byte <= din_one_reg;
    end
  end

  // ==========================================================
  // Output shifter, driven on falling serial clock
  always_comb begin
    case (cls_reg.kind)
      K_SR_READ: begin
        if (opcode_reg == OPC_READ_SR_TWO) begin
          out_src = status_byte_two;
        end else if (opcode_reg == OPC_READ_SR_THREE) begin
          out_src = status_byte_three;
        end else begin
          out_src = status_byte_one;
        end
      end
      K_UA_READ: out_src = upper_address_byte;
      K_RPD: out_src = DEVICE_ID;
      default: out_src = read_byte;
    endcase
    out_data = (out_cnt_reg == 3'h0) ? out_src : out_sr_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_sr_reg <= 8'h00;
      out_cnt_reg <= 3'h0;
      spi_io_out <= 4'h0;
      spi_io_oe <= 4'h0;
      read_byte_next <= 1'b0;
    end else begin
      read_byte_next <= 1'b0;
      if (state_reg != S_DOUT) begin
        out_cnt_reg <= 3'h0;
        spi_io_oe <= 4'h0;
      end else if (sck_fall) begin
        read_byte_next <= (out_cnt_reg == 3'h0) && (cls_reg.kind == K_ARRAY_READ);
        if (cls_reg.out_lanes == LANES_4) begin
          spi_io_out <= out_data[7:4];
          spi_io_oe <= 4'hF;
          out_sr_reg <= {out_data[3:0], 4'h0};
          out_cnt_reg <= (out_cnt_reg == 3'h0) ? 3'h1 : out_cnt_reg - 3'h1;
        end else if (cls_reg.out_lanes == LANES_2) begin
          spi_io_out <= {2'b00, out_data[7:6]};
          spi_io_oe <= 4'h3;
          out_sr_reg <= {out_data[5:0], 2'b00};
          out_cnt_reg <= (out_cnt_reg == 3'h0) ? 3'h3 : out_cnt_reg - 3'h1;
        end else begin
          spi_io_out <= {2'b00, out_data[7], 1'b0};
          spi_io_oe <= 4'h2;
          out_sr_reg <= {out_data[6:0], 1'b0};
          out_cnt_reg <= (out_cnt_reg == 3'h0) ? 3'h7 : out_cnt_reg - 3'h1;
        end
      end
    end
  end

endmodule : fcfe_front_end

`default_nettype wire

//--- logic/fcfe_pkg.sv
// Shared constants, encodings and carriers of the flash command front end.
// Assumes the importer runs on the single system clock mclk.
`default_nettype none

package fcfe_pkg;

  // ==========================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 32;
  localparam int LOW_ADDR_W = 24;
  localparam int IO_W = 4;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_VOL_SR_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_READ_SR_ONE = 8'h05;
  localparam logic [7:0] OPC_READ_SR_TWO = 8'h35;
  localparam logic [7:0] OPC_READ_SR_THREE = 8'h15;
  localparam logic [7:0] OPC_WRITE_SR = 8'h01;
  localparam logic [7:0] OPC_WRITE_SR_TWO = 8'h31;
  localparam logic [7:0] OPC_WRITE_SR_THREE = 8'h11;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OPC_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OPC_RELEASE_PD = 8'hAB;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_PAGE_PROGRAM_4B = 8'h12;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
  localparam logic [7:0] OPC_ERASE_4K_4B = 8'h21;
  localparam logic [7:0] OPC_ERASE_32K_4B = 8'h5C;
  localparam logic [7:0] OPC_ERASE_64K_4B = 8'hDC;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0B;
  localparam logic [7:0] OPC_READ_4B = 8'h13;
  localparam logic [7:0] OPC_FAST_READ_4B = 8'h0C;
  localparam logic [7:0] OPC_QUAD_OUT_READ_4B = 8'h6C;
  localparam logic [7:0] OPC_DUAL_IO_READ_4B = 8'hBC;
  localparam logic [7:0] OPC_UPPER_ADDR_WRITE = 8'hC5;
  localparam logic [7:0] OPC_UPPER_ADDR_READ = 8'hC8;

  // ==========================================================
  // Reset values, lane counts and phase lengths
  localparam logic [7:0] UPPER_ADDR_RESET = 8'h00;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [2:0] ADDR_NONE = 3'h0;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam logic [1:0] DUMMY_NONE = 2'h0;
  localparam logic [1:0] DUMMY_ONE = 2'h1;
  localparam logic [1:0] DUMMY_ID = 2'h3;
  localparam logic [2:0] CLK_MOD8_ZERO = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] DIN_NONE = 2'h0;
  localparam logic [1:0] DIN_ONE = 2'h1;
  localparam logic [1:0] DIN_MAX = 2'h3;
  localparam logic [2:0] SRW_SEL_ONE = 3'h1;
  localparam logic [2:0] SRW_SEL_TWO = 3'h2;
  localparam logic [2:0] SRW_SEL_THREE = 3'h4;

  // ==========================================================
  // Types
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_OPCODE = 7'h02,
    S_ADDR = 7'h04,
    S_DUMMY = 7'h08,
    S_DIN = 7'h10,
    S_DOUT = 7'h20,
    S_SKIP = 7'h40
  } fcfe_state_t;

  typedef enum logic [3:0] {
    K_IGNORE = 4'h0,
    K_SINGLE = 4'h1,
    K_ERASE = 4'h2,
    K_PROG = 4'h3,
    K_SRW = 4'h4,
    K_SR_READ = 4'h5,
    K_ARRAY_READ = 4'h6,
    K_RPD = 4'h7,
    K_UA_WRITE = 4'h8,
    K_UA_READ = 4'h9
  } fcfe_kind_t;

  typedef struct packed {
    fcfe_kind_t kind;
    logic [2:0] addr_bytes;
    logic [1:0] dummy_bytes;
    logic [2:0] in_lanes;
    logic [2:0] out_lanes;
  } fcfe_cls_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] address;
  } fcfe_cmd_t;

  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] byte_one;
    logic [7:0] byte_two;
    logic [7:0] byte_three;
  } fcfe_srw_t;

endpackage : fcfe_pkg

`default_nettype wire

//--- logic/fcfe_shift.sv
// Input deserialiser: gathers 1, 2 or 4 lanes per clock into bytes, MSB first.
// Assumes one sample strobe per serial rising edge, already synchronised.
`timescale 1ns/1ps
`default_nettype none

module fcfe_shift
  import fcfe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic sample,
  input wire logic [2:0] lanes,
  input wire logic [IO_W-1:0] io_in,
  // Result
  output logic [BYTE_W-1:0] byte_val,
  output logic byte_done
);

  logic [BYTE_W-1:0] acc_reg;
  logic [3:0] bit_cnt_reg;
  logic [BYTE_W-1:0] acc_next;
  logic [3:0] cnt_sum;

  // ==========================================================
  // Shift in by lane count, top lane carries the higher bit
  always_comb begin
    cnt_sum = bit_cnt_reg + {1'b0, lanes};
    if (lanes == LANES_4) begin
      acc_next = {acc_reg[3:0], io_in[3:0]};
    end else if (lanes == LANES_2) begin
      acc_next = {acc_reg[5:0], io_in[1:0]};
    end else begin
      acc_next = {acc_reg[6:0], io_in[0]};
    end
  end

  // Accumulator and byte completion
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_val <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (clear) begin
        bit_cnt_reg <= 4'h0;
      end else if (sample) begin
        acc_reg <= acc_next;
        if (cnt_sum >= BITS_PER_BYTE) begin
          byte_val <= acc_next;
          byte_done <= 1'b1;
          bit_cnt_reg <= 4'h0;
        end else begin
          bit_cnt_reg <= cnt_sum;
        end
      end
    end
  end

endmodule : fcfe_shift

`default_nettype wire

//--- logic/fcfe_sync.sv
// Two-flop synchroniser for pin levels entering the mclk domain.
// Assumes inputs are plain levels; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module fcfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one_reg;

  // ==========================================================
  // Two stages
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_one_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage_one_reg <= async_in;
      sync_out <= stage_one_reg;
    end
  end

endmodule : fcfe_sync

`default_nettype wire

//--- verification/fcfe_front_end_sva.sv
// Checker of the front end's command outcomes and pin enables.
// Assumes binding into fcfe_front_end; everything in the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module fcfe_sva
  import fcfe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins
  input wire logic spi_cs_n,
  input wire logic [IO_W-1:0] spi_io_oe,
  // Core side
  input wire logic four_byte_mode,
  input wire logic op_commit,
  input wire fcfe_cmd_t op_info,
  input wire logic read_start,
  input wire logic powerdown_release,
  input wire logic sr_write_valid,
  input wire fcfe_srw_t sr_write,
  input wire logic [7:0] upper_address_byte
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_idle; spi_cs_n [*5]; endsequence
  sequence s_desel; $past(spi_cs_n, 2); endsequence
  property p_oe_idle; s_idle |-> spi_io_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe high while idle");
  property p_commit; op_commit |-> s_desel; endproperty
  a_commit: assert property (p_commit) else $error("commit inside frame");
  property p_srw; sr_write_valid |-> s_desel ##0 sr_write.sel != 3'h0; endproperty
  a_srw: assert property (p_srw) else $error("bad status write");
  property p_upper; $changed(upper_address_byte) |-> s_desel ##0 !four_byte_mode; endproperty
  a_upper: assert property (p_upper) else $error("upper byte moved");
  property p_addr;
    read_start && !four_byte_mode |-> op_info.address[31:24] == upper_address_byte;
  endproperty
  a_addr: assert property (p_addr) else $error("upper byte not placed");
  property p_rel; powerdown_release |-> op_info.opcode == OPC_RELEASE_PD; endproperty
  a_rel: assert property (p_rel) else $error("stray release");
  property p_rd; read_start |-> !$past(spi_cs_n, 3); endproperty
  a_rd: assert property (p_rd) else $error("read outside frame");
  property p_oe; spi_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
  a_oe: assert property (p_oe) else $error("bad lane enable");
endmodule : fcfe_sva
bind fcfe_front_end fcfe_sva u_sva (.mclk, .sys_rst, .spi_cs_n, .spi_io_oe, .four_byte_mode,
  .op_commit, .op_info, .read_start, .powerdown_release, .sr_write_valid, .sr_write,
  .upper_address_byte);
`default_nettype wire

//--- verification/fcfe_host.sv
// Host controller model: mode 0 frames, MSB first on io0, io1 read back.
// Assumes a serial clock of ten mclk periods; clock stands low outside frames.
`timescale 1ns/1ps
`default_nettype none
module fcfe_host
  import fcfe_pkg::*;
(
  // Clock reference
  input wire logic mclk,
  // Serial pins
  output logic spi_clk,
  output logic spi_cs_n,
  output logic [IO_W-1:0] spi_io_in,
  input wire logic [IO_W-1:0] spi_io_out
);
  // ==========================================================
  // Frame driver
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_io_in = 4'hA;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Sends nbits of tx, samples io1 before each rise into rx
  task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    tick(1);
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_io_in[0] = tx[63-i];
      tick(5);
      rx = {rx[62:0], spi_io_out[1]};
      spi_clk = 1'b1;
      tick(5);
      spi_clk = 1'b0;
    end
    tick(5);
    spi_cs_n = 1'b1;
    spi_io_in = ~spi_io_in; // Released lines are not trusted
    tick(8);
  endtask : xfer
endmodule : fcfe_host
`default_nettype wire

//--- verification/tb_fcfe_front_end.sv
// Testbench of the front end: host frames in, command pulses checked.
// Assumes fcfe_host as far side and a 20 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module tb_fcfe_front_end
  import fcfe_pkg::*;
;
  // ==========================================================
  // Signals
  logic mclk = 1'b0, sys_rst = 1'b1, four_byte_mode = 1'b0;
  logic spi_clk, spi_cs_n, op_commit, read_start, prog_byte_valid, sr_write_valid;
  logic [IO_W-1:0] spi_io_in, spi_io_out, spi_io_oe;
  fcfe_cmd_t op_info;
  fcfe_srw_t sr_write, last_srw;
  logic [7:0] upper_address_byte, last_op, prog_byte, last_prog;
  logic [31:0] last_addr;
  logic [63:0] rx;
  logic [7:0] sr_val [3] = '{8'hA5, 8'h3C, 8'h81};
  logic [7:0] rd_op [3] = '{OPC_READ_SR_ONE, OPC_READ_SR_TWO, OPC_READ_SR_THREE};
  logic [7:0] one_op [3] = '{OPC_WRITE_ENABLE, OPC_VOL_SR_WRITE_ENABLE, OPC_WRITE_DISABLE};
  int errors = 0, checks_done = 0, n_commit = 0;
  initial forever #25 mclk = ~mclk;
  fcfe_host u_host (.mclk, .spi_clk, .spi_cs_n, .spi_io_in, .spi_io_out);
  fcfe_front_end #(.DEVICE_ID(8'h5A)) u_dut (.mclk, .sys_rst, .spi_clk, .spi_cs_n,
    .spi_io_in, .spi_io_out, .spi_io_oe, .four_byte_mode, .status_byte_one(sr_val[0]),
    .status_byte_two(sr_val[1]), .status_byte_three(sr_val[2]), .read_byte(8'h96),
    .op_commit, .op_info, .read_start, .read_byte_next(), .prog_byte_valid,
    .prog_byte, .powerdown_release(), .sr_write_valid, .sr_write,
    .upper_address_byte);
  // Pulse monitor
  always @(posedge mclk) begin
    if (op_commit === 1'b1) begin
      n_commit++;
      last_op = op_info.opcode;
    end
    if (read_start === 1'b1) last_addr = op_info.address;
    if (prog_byte_valid === 1'b1) last_prog = prog_byte;
    if (sr_write_valid === 1'b1) last_srw = sr_write;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    check(upper_address_byte, 8'h00);
    for (int k = 0; k < 3; k++) begin
      u_host.xfer({one_op[k], 56'h0}, 8, rx);
      check(last_op, one_op[k]);
      u_host.xfer({rd_op[k], 56'h0}, 16, rx);
      check(rx[7:0], sr_val[k]);
    end
    u_host.xfer({OPC_WRITE_ENABLE, 56'h0}, 9, rx);
    u_host.xfer({8'hFF, 56'h0}, 8, rx);
    u_host.xfer({OPC_PAGE_PROGRAM, 24'h0, 8'h55, 24'h0}, 44, rx);
    check(n_commit, 32'h3);
    u_host.xfer({OPC_PAGE_PROGRAM, 24'h0, 8'hC3, 24'h0}, 40, rx);
    check(last_op, OPC_PAGE_PROGRAM);
    check(last_prog, 8'hC3);
    u_host.xfer({OPC_WRITE_SR, 16'h1234, 40'h0}, 24, rx);
    check(last_srw, 27'h3123400);
    u_host.xfer({OPC_UPPER_ADDR_WRITE, 8'h01, 48'h0}, 16, rx);
    check(upper_address_byte, 8'h01);
    u_host.xfer({OPC_UPPER_ADDR_READ, 56'h0}, 16, rx);
    check(rx[7:0], 8'h01);
    u_host.xfer({OPC_READ, 24'hFFFFFF, 32'h0}, 48, rx);
    check(last_addr, 32'h01FFFFFF);
    check(rx[15:0], 16'h9696);
    check(upper_address_byte, 8'h01);
    four_byte_mode = 1'b1;
    u_host.xfer({OPC_UPPER_ADDR_WRITE, 8'h00, 48'h0}, 16, rx);
    check(upper_address_byte, 8'h01);
    u_host.xfer({OPC_READ, 32'h00ABCDEF, 24'h0}, 48, rx);
    check(last_addr, 32'h00ABCDEF);
    u_host.xfer({OPC_QUAD_OUT_READ_4B, 56'h0}, 50, rx);
    check(rx[1:0], 2'h1);
    u_host.xfer({OPC_RELEASE_PD, 56'h0}, 8, rx);
    u_host.xfer({OPC_RELEASE_PD, 56'h0}, 40, rx);
    check(rx[7:0], 8'h5A);
    give_verdict();
  end
endmodule : tb_fcfe_front_end
`default_nettype wire
